// ---- asc_top.sv ----
`timescale 1ns/1ps
//
// Function
// [R1] done flag sets only after all four slots hold results; not writable
// [R2] any control write clears done flag and restarts the sequence; the code does so only when pstrb[0] is set
// [R3] in repeat mode done flag rises after first full sequence
// [R4] control bit 6 always reads zero
// [R5] without repeat: four conversions once, then halt until next write
// [R6] with repeat: endless round-robin, each slot updated as result arrives
// [R7] single mode converts channel in bits 3..0 four times
// [R8] group mode converts four channels once each, one slot each
// [R9] group mode ignores low two select bits, high two pick group
// [R10] codes 0..7 are external inputs; slot follows low two code bits
// [R11] 10xx reserved; 1100 high ref, 1101 low ref, 1110 half, 1111 test
// [R12] result slots are 8-bit, read only, writes ignored
// [R13] software trusts results only once done flag reads set
// [R14] repeating group resamples each channel every 64 us at 2 MHz
// [R15] sequence starts one e-clock after the triggering write
// [R16] repeating single mode: fifth result to slot one, cyclically
// [R17] control bit 7 read-only done flag, bit 6 zero, rest read/write
//
module asc_top
#(
    parameter int CONV_LEN  = asc_pkg::CONV_CYCLES,
    parameter int E_LEN     = asc_pkg::CLK_PER_E
)
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output asc_pkg::asc_conv_req_t     conv_req,
    input  wire logic                  conv_done,
    input  wire logic [7:0]            conv_result,
    output logic                       irq
);
    import asc_pkg::*;

    // ==========================================================
    // elaboration checks
    // ==========================================================
    // the pacing counter is 16 bits wide, so longer spans cannot be counted
    if (CONV_LEN < 2 || CONV_LEN > 65535 || E_LEN < 1 || E_LEN > 65535)
    begin : g_bad_timing
        $error("asc_top: timing parameter out of range");
    end

    // ==========================================================
    // bus decode
    // ==========================================================
    function automatic logic [11:0] word_addr(input logic [15:0] index);
        word_addr = {index[9:0], 2'b00};
    endfunction : word_addr

    logic        access;
    logic        wr_en;
    logic        rd_en;
    logic        ctrl_wr;
    logic        mapped;
    assign access  = psel && penable && !pready;
    assign wr_en   = access && pwrite;
    assign rd_en   = access && !pwrite;
    assign ctrl_wr = wr_en && paddr == word_addr(CTRL_INDEX) && pstrb[0];

    // address is mapped when it hits any of the eight words
    always_comb
    begin
        mapped = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (paddr == word_addr(CTRL_INDEX + 16'(i)))
            begin
                mapped = 1'b1;
            end
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    logic [5:0]          ctrl_reg;
    logic                done_reg;
    logic [7:0]          slot_reg [4];
    logic [IRQ_BITS-1:0] irq_stat_reg;
    logic [IRQ_BITS-1:0] irq_en_reg;
    asc_state_t          state_reg;
    logic [15:0]         cnt_reg;
    logic [1:0]          idx_reg;
    logic [2:0]          filled_reg;
    logic                busy_reg;

    // writable control bits; bit 7 and bit 6 are not stored here
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            ctrl_reg <= CTRL_RESET[5:0];
        else if (ctrl_wr)
            ctrl_reg <= pwdata[5:0] & CTRL_WR_MASK[5:0]; // R17
    end

    logic       repeat_mode;
    logic       group_mode;
    logic [3:0] sel_code;
    assign repeat_mode = ctrl_reg[REPEAT_POS];
    assign group_mode  = ctrl_reg[GROUP_POS];
    assign sel_code    = ctrl_reg[3:0];

    // channel for the current slot: group takes high bits plus slot index
    function automatic logic [3:0] pick_channel(input logic grp,
                                                input logic [3:0] code,
                                                input logic [1:0] idx);
        if (grp)
            pick_channel = {code[3:2], idx}; // R8 R9 R10
        else
            pick_channel = code; // R7
    endfunction : pick_channel

    // ==========================================================
    // sequencer
    // ==========================================================
    logic result_in;
    logic last_slot;
    logic start_now;
    // an answer counts only for a request the core has already taken, so a
    // late answer from an abandoned conversion cannot fill a fresh slot
    assign result_in = state_reg == ST_CONV && busy_reg && !conv_req.start && conv_done;
    assign last_slot = idx_reg == 2'd3;
    // next request once the last one is answered and its paced slot is over
    assign start_now = state_reg == ST_CONV && !busy_reg && cnt_reg == 16'(CONV_LEN - 1)
                     && !ctrl_wr; // R14

    // state: delay one e-clock after write, then convert slot by slot
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            state_reg <= ST_IDLE;
        else if (ctrl_wr)
            state_reg <= ST_DELAY; // R2 R15
        else
        begin
            case (state_reg)
                ST_IDLE:  state_reg <= ST_IDLE;
                ST_DELAY:
                    if (cnt_reg == 16'(E_LEN - 1))
                        state_reg <= ST_CONV;
                ST_CONV:
                    if (result_in && last_slot && !repeat_mode)
                        state_reg <= ST_IDLE; // R5
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    // shared counter: delay, then request spacing of CONV_LEN clocks;
    // a slow core stretches the spacing, it never shortens it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cnt_reg <= 16'h0000;
        else if (ctrl_wr || start_now)
            cnt_reg <= 16'h0000;
        else if (state_reg == ST_DELAY && cnt_reg == 16'(E_LEN - 1))
            cnt_reg <= 16'(CONV_LEN - 1); // first request goes out at once
        else if (state_reg == ST_DELAY
                 || (state_reg == ST_CONV && cnt_reg != 16'(CONV_LEN - 1)))
            cnt_reg <= cnt_reg + 16'h0001; // R14
    end

    // one request outstanding at a time; a control write drops it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            busy_reg <= 1'b0;
        else if (ctrl_wr || result_in)
            busy_reg <= 1'b0; // R2
        else if (start_now)
            busy_reg <= 1'b1;
    end

    // slot index wraps round-robin
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            idx_reg <= 2'd0;
        else if (ctrl_wr)
            idx_reg <= 2'd0;
        else if (result_in)
            idx_reg <= idx_reg + 2'd1; // R6 R16
    end

    // count of slots filled since the last write
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            filled_reg <= 3'd0;
        else if (ctrl_wr)
            filled_reg <= 3'd0;
        else if (result_in && filled_reg != 3'd4)
            filled_reg <= filled_reg + 3'd1;
    end

    // done flag: write clears, fourth valid result sets
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            done_reg <= 1'b0;
        else if (ctrl_wr)
            done_reg <= 1'b0; // R2
        else if (result_in && filled_reg == 3'd3)
            done_reg <= 1'b1; // R1 R3
    end

    // result slots; no bus path writes them
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < 4; i++)
                slot_reg[i] <= RESULT_RESET;
        end
        else if (result_in && !ctrl_wr)
            slot_reg[idx_reg] <= conv_result; // R12
    end

    // request to analog core; reference codes pass straight through
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            conv_req <= '0;
        else
        begin
            conv_req.start   <= start_now; // R14
            conv_req.channel <= pick_channel(group_mode, sel_code, idx_reg); // R11
        end
    end

    // ==========================================================
    // interrupts
    // ==========================================================
    logic [IRQ_BITS-1:0] irq_set;
    logic [IRQ_BITS-1:0] irq_clr;
    assign irq_set[IRQ_DONE_POS] = result_in && filled_reg == 3'd3 && !ctrl_wr;
    assign irq_set[IRQ_SLOT_POS] = result_in && !ctrl_wr;
    assign irq_clr = (wr_en && paddr == word_addr(IRQ_CLEAR_INDEX))
                   ? pwdata[IRQ_BITS-1:0] : '0;

    // sticky status; set wins over clear
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq_stat_reg <= '0;
        else
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq_en_reg <= '0;
        else if (wr_en && paddr == word_addr(IRQ_ENABLE_INDEX))
            irq_en_reg <= pwdata[IRQ_BITS-1:0];
    end

    // next-state view so irq leaves a flop yet tracks status
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end

    // ==========================================================
    // bus response: one wait state, then pready
    // ==========================================================
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            word_addr(CTRL_INDEX):
                rd_mux = {24'h00_0000, done_reg, 1'b0, ctrl_reg}; // R4 R17
            word_addr(SLOT_ONE_INDEX):   rd_mux = {24'h00_0000, slot_reg[0]};
            word_addr(SLOT_TWO_INDEX):   rd_mux = {24'h00_0000, slot_reg[1]};
            word_addr(SLOT_THREE_INDEX): rd_mux = {24'h00_0000, slot_reg[2]};
            word_addr(SLOT_FOUR_INDEX):  rd_mux = {24'h00_0000, slot_reg[3]};
            word_addr(IRQ_STATUS_INDEX): rd_mux = {30'h0000_0000, irq_stat_reg};
            word_addr(IRQ_ENABLE_INDEX): rd_mux = {30'h0000_0000, irq_en_reg};
            default:                     rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= access;
            pslverr <= access && !mapped;
            prdata  <= rd_en ? rd_mux : 32'h0000_0000;
        end
    end

endmodule : asc_top

// ---- asc_pkg.sv ----
package asc_pkg;

    // ==========================================================
    // register map: word indices; byte address is four times the index,
    // and only the low ten index bits are decoded
    // ==========================================================
    localparam logic [15:0] CTRL_INDEX        = 16'h1030;
    localparam logic [15:0] SLOT_ONE_INDEX    = 16'h1031;
    localparam logic [15:0] SLOT_TWO_INDEX    = 16'h1032;
    localparam logic [15:0] SLOT_THREE_INDEX  = 16'h1033;
    localparam logic [15:0] SLOT_FOUR_INDEX   = 16'h1034;
    localparam logic [15:0] IRQ_STATUS_INDEX  = 16'h1035;
    localparam logic [15:0] IRQ_ENABLE_INDEX  = 16'h1036;
    localparam logic [15:0] IRQ_CLEAR_INDEX   = 16'h1037;

    // ==========================================================
    // control/status fields
    // ==========================================================
    localparam int DONE_POS   = 7;
    localparam int ZERO_POS   = 6;
    localparam int REPEAT_POS = 5;
    localparam int GROUP_POS  = 4;
    localparam logic [7:0] CTRL_WR_MASK  = 8'h3f;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] RESULT_RESET  = 8'h00;

    // interrupt bits: sequence done, result slot written
    localparam int IRQ_DONE_POS = 0;
    localparam int IRQ_SLOT_POS = 1;
    localparam int IRQ_BITS     = 2;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_MHZ         = 40;
    localparam int E_CLK_MHZ       = 2;
    localparam int GROUP_PERIOD_US = 64;
    // one group of four every 64 us at 2 MHz: 32 e-clocks per conversion
    localparam int E_PER_CONV      = GROUP_PERIOD_US * E_CLK_MHZ / 4;
    localparam int CLK_PER_E       = CLK_MHZ / E_CLK_MHZ;
    localparam int CONV_CYCLES     = E_PER_CONV * CLK_PER_E;

    // channel codes
    localparam logic [3:0] CODE_HIGH_REF = 4'h0c;
    localparam logic [3:0] CODE_LOW_REF  = 4'h0d;
    localparam logic [3:0] CODE_HALF_REF = 4'h0e;
    localparam logic [3:0] CODE_TEST     = 4'h0f;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV  = 2'b10
    } asc_state_t;

    // request to the analog core
    typedef struct packed
    {
        logic       start;
        logic [3:0] channel;
    } asc_conv_req_t;

endpackage : asc_pkg

// ---- asc_props.sv ----
`timescale 1ns/1ps
// ==========================================
// bus and converter request checks
module asc_props
    import asc_pkg::*;
#(
    parameter int E_LEN = 20
)
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input asc_conv_req_t    conv_req,
    input wire logic        conv_done,
    input wire logic [7:0]  conv_result,
    input wire logic        irq
);
    // request leaves one e-clock after the access edge plus the state and
    // request register stages; a little slack above that
    localparam int E_LO = E_LEN + 2;
    localparam int E_HI = E_LEN + 4;
    logic ctrl_a;
    logic hit;
    assign ctrl_a = paddr == {CTRL_INDEX[9:0], 2'b00};
    assign hit = paddr[1:0] == 2'b00 && paddr[11:2] >= 10'h030 && paddr[11:2] <= 10'h037;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    ready_time_a: assert property ($rose(penable) && psel |=> pready) else $error("late pready");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
    idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata idle");
    narrow_data_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("wide read data");
    bit_six_a: assert property (pready && !pwrite && ctrl_a |-> !prdata[6])
        else $error("bit six set");
    unmapped_a: assert property (pready && !hit |-> pslverr) else $error("no slverr");
    start_pulse_a: assert property (conv_req.start |=> !conv_req.start) else $error("long start");
    start_delay_a: assert property (psel && penable && pwrite && ctrl_a && !pready
        |-> ##[E_LO:E_HI] conv_req.start) else $error("no start after write");
endmodule : asc_props

// ---- asc_core_model.sv ----
`timescale 1ns/1ps
// ==========================================
// behavioural analog core: result is {salt, channel}
module asc_core_model
    import asc_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input asc_conv_req_t   conv_req,
    input wire logic [3:0] salt,
    input wire logic [3:0] lat,
    output logic           conv_done,
    output logic [7:0]     conv_result,
    output int             n_starts
);
    logic [3:0] ch;
    logic [7:0] val;
    int         cnt;
    // outside the done pulse the bus shows garbage, not the last result
    assign conv_result = conv_done ? val : ~val;
    // latency set by the bench, a later start restarts the count
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            conv_done <= 1'b0;
            ch <= 4'h0;
            val <= 8'h00;
            cnt <= 0;
            n_starts <= 0;
        end
        else
        begin
            // a restart drops the answer of the conversion it replaces
            conv_done <= cnt == 1 && !conv_req.start;
            if (cnt != 0) cnt <= cnt - 1;
            if (cnt == 1) val <= {salt, ch};
            if (conv_req.start)
            begin
                ch <= conv_req.channel;
                cnt <= int'(lat);
                n_starts <= n_starts + 1;
            end
        end
    end
endmodule : asc_core_model

// ---- tb_adc_sequence_control.sv ----
`timescale 1ns/1ps
// ==========================================
// sequencer bench over apb
module tb_adc_sequence_control;
    import asc_pkg::*;
    localparam int E_LEN = 2;
    localparam int CONV_LEN = 8;
    logic          clk, reset, psel, penable, pwrite, pready, pslverr, irq, conv_done, rerr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rdat;
    logic [7:0]    conv_result;
    logic [3:0]    salt, lat;
    asc_conv_req_t conv_req;
    int            n_starts, n_errors, num_checks, j, g, s;
    asc_top #(.E_LEN(E_LEN), .CONV_LEN(CONV_LEN)) asc_top_i (.clk(clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_req(conv_req),
        .conv_done(conv_done), .conv_result(conv_result), .irq(irq));
    asc_core_model asc_core_model_i (.clk(clk), .reset(reset), .conv_req(conv_req),
        .salt(salt), .lat(lat), .conv_done(conv_done), .conv_result(conv_result),
        .n_starts(n_starts));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [11:0] ad(input logic [15:0] i);
        return {i[9:0], 2'b00};
    endfunction : ad
    // one apb transfer, held until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // reads until the value shows up, bounded
    task automatic poll(input logic [11:0] a, input logic [31:0] exp);
        for (s = 0; s < 80; s++)
        begin
            xfer(1'b0, a, 32'h0000_0000);
            if (rdat === exp) break;
        end
        chk(rdat, exp);
    endtask : poll
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial
    begin
        #500000;
        n_errors++;
        conclude();
    end
    initial
    begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {salt, lat, n_errors, num_checks} = {8'h13, 64'h0};
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        xfer(1'b0, ad(CTRL_INDEX), 0); chk(rdat, 32'h0000_0000);
        xfer(1'b0, 12'h004, 0); chk({31'h0, rerr}, 32'h0000_0001);
        // single channel once, flag and bit six unwritable
        xfer(1'b1, ad(IRQ_ENABLE_INDEX), 32'h0000_0001);
        xfer(1'b1, ad(CTRL_INDEX), 32'h0000_00c3);
        xfer(1'b0, ad(CTRL_INDEX), 0); chk(rdat, 32'h0000_0003);
        poll(ad(CTRL_INDEX), 32'h0000_0083);
        chk(irq, 32'h0000_0001);
        for (j = 0; j < 4; j++)
        begin
            xfer(1'b0, ad(16'(SLOT_ONE_INDEX + j)), 0); chk(rdat, {24'h0, salt, 4'h3});
        end
        g = n_starts;
        repeat (40) @(posedge clk);
        chk(n_starts, g);
        xfer(1'b1, ad(SLOT_ONE_INDEX), 32'h0000_00ff);
        xfer(1'b0, ad(SLOT_ONE_INDEX), 0); chk(rdat, {24'h0, salt, 4'h3});
        // interrupt status, clear and mask
        xfer(1'b0, ad(IRQ_STATUS_INDEX), 0); chk(rdat, 32'h0000_0003);
        xfer(1'b1, ad(IRQ_CLEAR_INDEX), 32'h0000_0003);
        xfer(1'b0, ad(IRQ_STATUS_INDEX), 0); chk(rdat, 32'h0000_0000);
        chk(irq, 32'h0000_0000);
        xfer(1'b1, ad(IRQ_ENABLE_INDEX), 32'h0000_0000);
        // every group, low select bits set but ignored
        for (g = 0; g < 4; g++)
        begin
            salt <= 4'(g + 4);
            xfer(1'b1, ad(CTRL_INDEX), 32'h13 | (g << 2));
            poll(ad(CTRL_INDEX), 32'h93 | (g << 2));
            for (j = 0; j < 4; j++)
            begin
                xfer(1'b0, ad(16'(SLOT_ONE_INDEX + j)), 0);
                chk(rdat, {24'h0, salt, 2'(g), 2'(j)});
            end
        end
        chk(irq, 32'h0000_0000);
        // slow core, repeat single, restarted mid-run
        lat <= 4'h9;
        salt <= 4'h1;
        xfer(1'b1, ad(CTRL_INDEX), 32'h0000_0025);
        xfer(1'b0, ad(CTRL_INDEX), 0); chk(rdat, 32'h0000_0025);
        repeat (20) @(posedge clk);
        xfer(1'b1, ad(CTRL_INDEX), 32'h0000_0025);
        poll(ad(CTRL_INDEX), 32'h0000_00a5);
        salt <= 4'h2;
        poll(ad(SLOT_FOUR_INDEX), 32'h0000_0025);
        poll(ad(SLOT_ONE_INDEX), 32'h0000_0025);
        xfer(1'b0, ad(CTRL_INDEX), 0); chk(rdat, 32'h0000_00a5);
        // repeating group on a fast core: exactly one request per paced slot
        lat <= 4'h3;
        xfer(1'b1, ad(CTRL_INDEX), 32'h0000_0030);
        poll(ad(CTRL_INDEX), 32'h0000_00b0);
        g = n_starts;
        repeat (4 * CONV_LEN) @(posedge clk);
        chk(n_starts - g, 32'h0000_0004);
        conclude();
    end
endmodule : tb_adc_sequence_control
bind asc_top asc_props #(.E_LEN(E_LEN)) asc_props_i (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_req(conv_req),
    .conv_done(conv_done), .conv_result(conv_result), .irq(irq));
